// ==== adf_sequencer.sv ====
// How it works
// - Filter path is chosen from rate code together with filter select.
// - Oversampling ratio depends on rate code only, never on filter type.
// - Each conversion consumes exactly the ratio count of modulator clocks.
// - Rate code decodes to falling ratios, 102400 down to 64; top three codes give 64.
// - One select bit picks low-latency boxcar or higher-order decimator.
// - Low-latency results settle within a single output data period.
// - Start on start pin rising edge or host start command pulse.
// - Coded delay precedes first, single-shot and every chop conversion, not later non-chop ones.
// - First result adds delay and overhead; later ones take one period, plus the delay with chop.
// - Offset and gain compensation applied during the overhead time.
// - Low-latency timing follows from ratio, delay and overhead counts.
// - Higher-order timing follows from settling conversions plus overhead.
// - Higher-order settles in 5 conversions at fast rates, else 3.
// - All timing counts master clock ticks, so it scales with them.
// - Chop averages one normal and one reversed polarity conversion.
// - Chop runs as repeated single shots, swapping polarity each time.
// - Continuous chop: first after two conversions, then every conversion.
// - Modulator sample strobe is one sixteenth of master clock ticks.
`timescale 1ns/1ps
`default_nettype none
module adf_sequencer (
   input  wire logic                     clock_in,
   input  wire logic                     reset_in,
   input  wire logic                     mclk_tick_in,
   input  wire logic                     mod_bit_in,
   input  wire logic                     start_pin_in,
   input  wire logic                     start_cmd_in,
   input  wire logic                     continuous_in,
   input  wire logic [3:0]               rate_code_in,
   input  wire logic                     high_order_decimator_in,
   input  wire logic                     chop_en_in,
   input  wire logic [2:0]               delay_code_in,
   input  wire logic [adf_pkg::RES_W-1:0] offset_in,
   input  wire logic [adf_pkg::RES_W-1:0] gain_in,
   output logic                          mod_sample_out,
   output logic                          polarity_swap_out,
   output logic                          busy_out,
   output logic                          result_valid_out,
   output logic [adf_pkg::RES_W-1:0]     result_out
);
   import adf_pkg::*;

   adf_dec_if dec_bus ();

   adf_boxcar u_boxcar (
      .clock_in (clock_in),
      .reset_in (reset_in),
      .dec      (dec_bus.dec)
   );

   adf_state_t              state;
   logic [DIV_W-1:0]        div;
   logic                    mod_tick;
   logic                    start_q;
   logic [7:0]              cfg_q;
   logic [DLY_W-1:0]        wait_cnt;
   logic [SET_W-1:0]        settle_cnt;
   logic signed [RAW_W-1:0] hist [0:3];
   logic                    first;
   logic                    have_prev;
   logic                    pol;
   logic signed [FLT_W-1:0] prev;
   logic signed [FLT_W-1:0] pre;
   logic                    emit_pend;
   logic                    valid;
   logic [RES_W-1:0]        result;
   adf_state_t              next_state;
   logic [DIV_W-1:0]        next_div;
   logic                    next_mod_tick;
   logic [DLY_W-1:0]        next_wait_cnt;
   logic [SET_W-1:0]        next_settle_cnt;
   logic signed [RAW_W-1:0] next_hist [0:3];
   logic                    next_first;
   logic                    next_have_prev;
   logic                    next_pol;
   logic signed [FLT_W-1:0] next_prev;
   logic signed [FLT_W-1:0] next_pre;
   logic                    next_emit_pend;
   logic                    next_valid;
   logic [RES_W-1:0]        next_result;
   logic                    start_evt;
   logic                    restart;
   logic                    run_on;
   logic                    goto_sample;
   logic [SET_W-1:0]        need;
   logic signed [FLT_W-1:0] raw_x;
   logic signed [FLT_W-1:0] flt;
   logic signed [FLT_W-1:0] chop_avg;
   logic signed [RES_W:0]   diff;
   logic signed [RES_W+RES_W+1:0] prod;
   logic signed [RES_W+RES_W+1:0] scaled;
   logic [RES_W-1:0]        comp;

   always_comb begin
      next_div      = mclk_tick_in ? div + 4'h1 : div;
      next_mod_tick = mclk_tick_in && div == 4'(MCLK_DIV - 1);
   end

   assign start_evt = (start_pin_in && !start_q) || start_cmd_in;
   assign restart   = state != ST_IDLE &&
                      cfg_q != {rate_code_in, high_order_decimator_in,
                                chop_en_in, 2'h0};
   assign run_on    = continuous_in && !chop_en_in;
   always_comb begin
      if (!high_order_decimator_in)
         need = SETTLE_LOW_LAT;
      else if (rate_code_in >= FAST_RATE_CODE)
         need = SETTLE_FAST;
      else
         need = SETTLE_SLOW;
   end

   always_comb begin
      raw_x = FLT_W'(dec_bus.raw);
      if (!high_order_decimator_in)
         flt = raw_x;
      else if (need == SETTLE_FAST)
         flt = (raw_x + (FLT_W'(hist[0]) <<< 2) +
                FLT_W'(hist[1]) * 23'sh000006 +
                (FLT_W'(hist[2]) <<< 2) + FLT_W'(hist[3])) >>> 4;
      else
         flt = (raw_x + (FLT_W'(hist[0]) <<< 1) + FLT_W'(hist[1])) >>> 2;
      chop_avg = pol ? (prev - flt) >>> 1 : (flt - prev) >>> 1;
   end

   always_comb begin
      diff   = (RES_W+1)'(pre <<< RAW_SHIFT) -
               $signed({offset_in[RES_W-1], offset_in});
      prod   = diff * $signed({1'b0, gain_in});
      scaled = prod >>> GAIN_SHIFT;
      if (scaled > $signed({26'h0, POS_FULL[RES_W-2:0]}))
         comp = POS_FULL;
      else if (scaled < -$signed({26'h0, NEG_FULL}))
         comp = NEG_FULL;
      else
         comp = scaled[RES_W-1:0];
   end

   assign dec_bus.osr   = adf_osr(rate_code_in);
   assign dec_bus.bit_v = mod_bit_in;
   assign dec_bus.tick  = mod_tick &&
                          (state == ST_SAMPLE || (state == ST_CALC && run_on));
   assign goto_sample   = state == ST_DELAY && wait_cnt == '0 && !restart;
   assign dec_bus.clear = goto_sample || restart;

   always_comb begin
      next_state      = state;
      next_wait_cnt   = wait_cnt;
      next_settle_cnt = settle_cnt;
      next_hist       = hist;
      next_first      = first;
      next_have_prev  = have_prev;
      next_pol        = pol;
      next_prev       = prev;
      next_pre        = pre;
      next_emit_pend  = 1'b0;
      next_valid      = 1'b0;
      next_result     = result;
      if (emit_pend) begin
         next_valid  = 1'b1;
         next_result = comp;
      end
      if (start_evt || restart) begin
         next_state      = ST_DELAY;
         next_wait_cnt   = adf_delay(delay_code_in);
         next_settle_cnt = '0;
         next_first      = 1'b1;
         next_have_prev  = 1'b0;
         next_pol        = 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_DELAY: begin
               if (wait_cnt == '0)
                  next_state = ST_SAMPLE;
               else if (mod_tick)
                  next_wait_cnt = wait_cnt - 9'h001;
            end
            ST_SAMPLE, ST_CALC: begin
               if (state == ST_CALC && mod_tick) begin
                  // Count down first, so a reloaded chop delay below wins.
                  next_wait_cnt = wait_cnt - 9'h001;
                  if (wait_cnt == 9'h001) begin
                     next_emit_pend = 1'b1;
                     next_first     = 1'b0;
                     if (chop_en_in && continuous_in) begin
                        next_state    = ST_DELAY;
                        next_wait_cnt = adf_delay(delay_code_in);
                     end else if (run_on) begin
                        next_state = ST_SAMPLE;
                     end else begin
                        next_state     = ST_IDLE;
                        next_have_prev = 1'b0;
                     end
                  end
               end
               if (dec_bus.done) begin
                  next_hist[0] = dec_bus.raw;
                  for (int i = 1; i < 4; i++) begin
                     next_hist[i] = hist[i-1];
                  end
                  if (settle_cnt + 3'h1 < need) begin
                     next_settle_cnt = settle_cnt + 3'h1;
                  end else if (chop_en_in) begin
                     next_prev       = flt;
                     next_pol        = !pol;
                     next_settle_cnt = '0;
                     next_have_prev  = 1'b1;
                     next_wait_cnt   = adf_delay(delay_code_in);
                     next_state      = ST_DELAY;
                     if (have_prev) begin
                        next_pre = chop_avg;
                        if (first) begin
                           next_state    = ST_CALC;
                           next_wait_cnt = OVERHEAD_TICKS;
                        end else begin
                           next_emit_pend = 1'b1;
                           if (!continuous_in)
                              next_state = ST_IDLE;
                        end
                     end
                  end else if (state == ST_SAMPLE) begin
                     next_pre = flt;
                     if (first) begin
                        next_state    = ST_CALC;
                        next_wait_cnt = OVERHEAD_TICKS;
                     end else begin
                        next_emit_pend = 1'b1;
                        if (!continuous_in)
                           next_state = ST_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         state      <= ST_IDLE;
         div        <= '0;
         mod_tick   <= 1'b0;
         start_q    <= 1'b0;
         cfg_q      <= '0;
         wait_cnt   <= '0;
         settle_cnt <= '0;
         hist       <= '{default: '0};
         first      <= 1'b1;
         have_prev  <= 1'b0;
         pol        <= 1'b0;
         prev       <= '0;
         pre        <= '0;
         emit_pend  <= 1'b0;
         valid      <= 1'b0;
         result     <= '0;
      end else begin
         state      <= next_state;
         div        <= next_div;
         mod_tick   <= next_mod_tick;
         start_q    <= start_pin_in;
         cfg_q      <= {rate_code_in, high_order_decimator_in,
                        chop_en_in, 2'h0};
         wait_cnt   <= next_wait_cnt;
         settle_cnt <= next_settle_cnt;
         hist       <= next_hist;
         first      <= next_first;
         have_prev  <= next_have_prev;
         pol        <= next_pol;
         prev       <= next_prev;
         pre        <= next_pre;
         emit_pend  <= next_emit_pend;
         valid      <= next_valid;
         result     <= next_result;
      end
   end

   assign mod_sample_out    = mod_tick;
   assign polarity_swap_out = pol;
   assign busy_out          = state != ST_IDLE;
   assign result_valid_out  = valid;
   assign result_out        = result;

   sequence start_seen_s;
      start_evt && !restart;
   endsequence
   sequence delay_armed_s;
      state == ST_DELAY && wait_cnt == adf_delay(delay_code_in);
   endsequence

   start_seq_a: assert property (@(posedge clock_in) disable iff (reset_in)
      start_seen_s |=> delay_armed_s or restart)
      else $error("start did not arm the delay");
   delay_end_a: assert property (@(posedge clock_in) disable iff (reset_in)
      goto_sample && !start_evt |=> state == ST_SAMPLE)
      else $error("delay end did not begin sampling");
   valid_pulse_a: assert property (@(posedge clock_in) disable iff (reset_in)
      result_valid_out |=> !result_valid_out)
      else $error("result valid longer than one cycle");
   valid_data_a: assert property (@(posedge clock_in) disable iff (reset_in)
      emit_pend |=> result_valid_out && result_out == $past(comp))
      else $error("result word not the compensated value");
   osr_top_a: assert property (@(posedge clock_in) disable iff (reset_in)
      rate_code_in >= TOP_RATE_CODE |-> dec_bus.osr == 17'h00040)
      else $error("top rate codes must give ratio 64");
   settle_fast_a: assert property (@(posedge clock_in) disable iff (reset_in)
      high_order_decimator_in && rate_code_in >= FAST_RATE_CODE
      |-> need == SETTLE_FAST)
      else $error("fast rates must settle in five conversions");
   mod_div_a: assert property (@(posedge clock_in) disable iff (reset_in)
      mod_tick |=> !mod_tick [*8])
      else $error("modulator strobe too frequent");
   restart_a: assert property (@(posedge clock_in) disable iff (reset_in)
      restart |=> state == ST_DELAY && settle_cnt == '0 && first)
      else $error("config change did not restart settling");
   chop_swap_a: assert property (@(posedge clock_in) disable iff (reset_in)
      $changed(pol) && !$past(start_evt) && !$past(restart)
      |-> $past(chop_en_in) && $past(dec_bus.done))
      else $error("polarity swapped outside a chop conversion end");
   calc_hold_a: assert property (@(posedge clock_in)
      disable iff (reset_in || start_evt || restart)
      state == ST_CALC && $past(state) != ST_CALC
      |-> state == ST_CALC [*8])
      else $error("overhead time shorter than expected");
endmodule : adf_sequencer
`default_nettype wire

// ==== adf_pkg.sv ====
`default_nettype none
package adf_pkg;
   // The ADC master clock arrives as one tick per master clock edge.
   localparam int unsigned MCLK_DIV      = 16;
   localparam int unsigned DIV_W         = 4;
   localparam int unsigned OSR_W         = 17;
   localparam int unsigned RAW_W         = 18;
   localparam int unsigned FLT_W         = 23;
   localparam int unsigned RES_W         = 24;
   localparam int unsigned DLY_W         = 9;
   localparam int unsigned SET_W         = 3;
   localparam logic [DLY_W-1:0] OVERHEAD_TICKS = 9'h008;
   localparam logic [SET_W-1:0] SETTLE_LOW_LAT = 3'h1;
   localparam logic [SET_W-1:0] SETTLE_FAST    = 3'h5;
   localparam logic [SET_W-1:0] SETTLE_SLOW    = 3'h3;
   localparam logic [3:0]       FAST_RATE_CODE = 4'hA;
   localparam logic [3:0]       TOP_RATE_CODE  = 4'hD;
   localparam int unsigned RAW_SHIFT     = 6;
   localparam int unsigned GAIN_SHIFT    = 23;
   localparam logic [RES_W-1:0] POS_FULL  = 24'h7FFFFF;
   localparam logic [RES_W-1:0] NEG_FULL  = 24'h800000;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_DELAY  = 2'h1,
      ST_SAMPLE = 2'h3,
      ST_CALC   = 2'h2
   } adf_state_t;

   function automatic logic [OSR_W-1:0] adf_osr(input logic [3:0] code);
      unique case (code)
         4'h0: adf_osr = 17'h19000;
         4'h1: adf_osr = 17'h0C800;
         4'h2: adf_osr = 17'h06400;
         4'h3: adf_osr = 17'h03C00;
         4'h4: adf_osr = 17'h03200;
         4'h5: adf_osr = 17'h01400;
         4'h6: adf_osr = 17'h010A8;
         4'h7: adf_osr = 17'h00A00;
         4'h8: adf_osr = 17'h00500;
         4'h9: adf_osr = 17'h00280;
         4'hA: adf_osr = 17'h00140;
         4'hB: adf_osr = 17'h00100;
         4'hC: adf_osr = 17'h00080;
         default: adf_osr = 17'h00040;
      endcase
   endfunction : adf_osr

   // Pre-conversion delay in modulator periods.
   function automatic logic [DLY_W-1:0] adf_delay(input logic [2:0] code);
      unique case (code)
         3'h0: adf_delay = 9'h000;
         3'h1: adf_delay = 9'h004;
         3'h2: adf_delay = 9'h008;
         3'h3: adf_delay = 9'h010;
         3'h4: adf_delay = 9'h020;
         3'h5: adf_delay = 9'h040;
         3'h6: adf_delay = 9'h080;
         default: adf_delay = 9'h100;
      endcase
   endfunction : adf_delay
endpackage : adf_pkg
`default_nettype wire

// ==== adf_dec_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface adf_dec_if;
   import adf_pkg::*;
   logic                    tick;
   logic                    bit_v;
   logic                    clear;
   logic [OSR_W-1:0]        osr;
   logic                    done;
   logic signed [RAW_W-1:0] raw;
   modport ctrl (output tick, bit_v, clear, osr, input done, raw);
   modport dec  (input tick, bit_v, clear, osr, output done, raw);
endinterface : adf_dec_if
`default_nettype wire

// ==== adf_boxcar.sv ====
`timescale 1ns/1ps
`default_nettype none
module adf_boxcar (
   input  wire logic clock_in,
   input  wire logic reset_in,
   adf_dec_if.dec    dec
);
   import adf_pkg::*;
   logic [OSR_W-1:0]        cnt;
   logic [OSR_W-1:0]        ones;
   logic                    done;
   logic signed [RAW_W-1:0] raw;
   logic [OSR_W-1:0]        next_cnt;
   logic [OSR_W-1:0]        next_ones;
   logic                    next_done;
   logic signed [RAW_W-1:0] next_raw;
   logic [OSR_W-1:0]        ones_now;

   // Boxcar over one full ratio settles in a single output period.
   always_comb begin
      ones_now  = ones + {{(OSR_W-1){1'b0}}, dec.bit_v};
      next_cnt  = cnt;
      next_ones = ones;
      next_done = 1'b0;
      next_raw  = raw;
      if (dec.clear) begin
         next_cnt  = '0;
         next_ones = '0;
      end else if (dec.tick) begin
         if (cnt == dec.osr - 17'h00001) begin
            next_cnt  = '0;
            next_ones = '0;
            next_done = 1'b1;
            next_raw  = $signed({ones_now, 1'b0}) - $signed({1'b0, dec.osr});
         end else begin
            next_cnt  = cnt + 17'h00001;
            next_ones = ones_now;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         cnt  <= '0;
         ones <= '0;
         done <= 1'b0;
         raw  <= '0;
      end else begin
         cnt  <= next_cnt;
         ones <= next_ones;
         done <= next_done;
         raw  <= next_raw;
      end
   end

   assign dec.done = done;
   assign dec.raw  = raw;

   osr_count_a: assert property (@(posedge clock_in) disable iff (reset_in)
      dec.tick && !dec.clear && cnt == dec.osr - 17'h00001 |=> done)
      else $error("conversion did not end after the ratio count");
endmodule : adf_boxcar
`default_nettype wire

// ==== adf_mod_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adf_mod_model (
   input  wire logic clock_in,
   input  wire logic slow_in,
   input  wire logic polarity_swap_in,
   output logic      mclk_tick_out,
   output logic      mod_bit_out
);
   // A full-scale positive input, so a reversed input flips every bit.
   // polarity flips stream
   always_comb mod_bit_out = ~polarity_swap_in;
   initial mclk_tick_out = 1'b1;
   always @(posedge clock_in) begin
      mclk_tick_out <= slow_in ? ~mclk_tick_out : 1'b1;
   end
endmodule : adf_mod_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adf_pkg::*;
   logic             clock_in, reset_in, tick, mbit, spin, scmd;
   logic             cont, hi, chop, slow, msamp, pol, busy, valid;
   logic [3:0]       rate;
   logic [2:0]       dly;
   logic [RES_W-1:0] offset, gain, result;
   logic [RES_W-1:0] exp_q[$];
   int               fails, checks_done, lat;

   adf_mod_model i_adf_mod_model (.clock_in(clock_in), .slow_in(slow),
      .polarity_swap_in(pol), .mclk_tick_out(tick), .mod_bit_out(mbit));
   adf_sequencer i_adf_sequencer (.clock_in(clock_in), .reset_in(reset_in),
      .mclk_tick_in(tick), .mod_bit_in(mbit), .start_pin_in(spin),
      .start_cmd_in(scmd), .continuous_in(cont), .rate_code_in(rate),
      .high_order_decimator_in(hi), .chop_en_in(chop),
      .delay_code_in(dly), .offset_in(offset), .gain_in(gain),
      .mod_sample_out(msamp), .polarity_swap_out(pol), .busy_out(busy),
      .result_valid_out(valid), .result_out(result));

   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end

   function automatic int osr_of(input logic [3:0] c);
      case (c)
         4'h9: return 640;
         4'hA: return 320;
         4'hB: return 256;
         4'hC: return 128;
         default: return 64;
      endcase
   endfunction : osr_of

   // Saturation is kept even though the chosen gains stay below it.
   function automatic logic [RES_W-1:0] expect_val(input int osr);
      longint v;
      v = ((longint'(osr) <<< 6) - longint'($signed(offset)));
      v = (v * longint'(gain)) >>> 23;
      if (v > 64'sh7FFFFF) return POS_FULL;
      if (v < -64'sh800000) return NEG_FULL;
      return v[RES_W-1:0];
   endfunction : expect_val

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [RES_W-1:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   task automatic in_range(input int lo, hi);
      check({23'h0, lat >= lo && lat <= hi}, 24'h000001);
   endtask : in_range

   // Counts edges up to the valid strobe, then checks it drops.
   task automatic wait_valid(input int limit);
      lat = 0;
      do begin
         @(posedge clock_in);
         #1;
         lat++;
         if (lat > limit) begin
            fails++;
            complete_run();
         end
      end while (valid !== 1'b1);
      @(posedge clock_in);
      #1;
      check({23'h0, valid}, 24'h000000);
   endtask : wait_valid

   task automatic conv(input logic [3:0] c, input logic h, ch, pin,
                       input logic [2:0] d, input int need, f);
      int span;
      @(posedge clock_in);
      rate <= c;
      hi <= h;
      chop <= ch;
      dly <= d;
      cont <= 1'b0;
      repeat (2) @(posedge clock_in);
      exp_q.push_back(expect_val(osr_of(c)));
      if (pin) spin <= 1'b1;
      else scmd <= 1'b1;
      @(posedge clock_in);
      scmd <= 1'b0;
      spin <= 1'b0;
      span = ((d == 0) ? 0 : (4 << (d - 1))) + need * osr_of(c);
      if (ch) span = 2 * span;
      span = (span + 8) * 16 * f;
      wait_valid(span + 400);
      in_range(span - 16 * f, span + 16 * f);
      check({23'h0, busy}, 24'h000000);
   endtask : conv

   always @(negedge clock_in) begin
      if (valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("CHECK FAILED at %0t: unexpected result", $time);
         end else check(result, exp_q.pop_front());
      end
   end

   initial begin
      {reset_in, spin, scmd, cont, hi, chop, slow} = 7'h40;
      rate = 4'hD;
      dly = 3'h0;
      fails = 0;
      checks_done = 0;
      void'($urandom(32'h99ffc016));
      offset = 24'($urandom_range(1023, 0));
      gain = 24'h400000 + 24'($urandom_range(32'h3FFFFF, 0));
      repeat (8) @(posedge clock_in);
      reset_in <= 1'b0;
      for (int c = 9; c < 16; c++) conv(4'(c), 1'b0, 1'b0, c[0], 3'h0, 1, 1);
      conv(4'hD, 1'b0, 1'b0, 1'b0, 3'h7, 1, 1);
      conv(4'hD, 1'b1, 1'b0, 1'b0, 3'h0, 5, 1);
      conv(4'h9, 1'b1, 1'b0, 1'b1, 3'h0, 3, 1);
      conv(4'hD, 1'b0, 1'b1, 1'b0, 3'h1, 1, 1);
      @(posedge clock_in) slow <= 1'b1;
      conv(4'hC, 1'b0, 1'b0, 1'b0, 3'h2, 1, 2);
      @(posedge clock_in) slow <= 1'b0;
      rate <= 4'hB;
      chop <= 1'b0;
      repeat (2) @(posedge clock_in);
      scmd <= 1'b1;
      @(posedge clock_in) scmd <= 1'b0;
      repeat (100) @(posedge clock_in);
      #1;
      lat = 0;
      while (msamp !== 1'b1 && lat < 64) begin
         @(posedge clock_in);
         #1;
         lat++;
      end
      if (lat >= 64) begin
         fails++;
         complete_run();
      end
      lat = 0;
      do begin
         @(posedge clock_in);
         #1;
         lat++;
      end while (msamp !== 1'b1 && lat < 64);
      check(24'(lat), 24'h000010);
      @(posedge clock_in) rate <= 4'hD;
      exp_q.push_back(expect_val(64));
      wait_valid(3000);
      in_range(1264, 1296);
      @(posedge clock_in) cont <= 1'b1;
      dly <= 3'h2;
      repeat (4) exp_q.push_back(expect_val(64));
      scmd <= 1'b1;
      @(posedge clock_in) scmd <= 1'b0;
      wait_valid(3000);
      in_range(1264, 1296);
      // Sampling runs on through the overhead, so the second result is early.
      for (int k = 0; k < 3; k++) begin
         wait_valid(3000);
         check(24'(lat), (k == 0) ? 24'h000380 : 24'h0003FF);
      end
      // continuous chop restarts, then one result per half
      @(posedge clock_in) chop <= 1'b1;
      dly <= 3'h1;
      repeat (3) exp_q.push_back(expect_val(64));
      wait_valid(3000);
      in_range(2288, 2320);
      repeat (2) begin
         wait_valid(3000);
         in_range(1072, 1104);
      end
      @(posedge clock_in) reset_in <= 1'b1;
      cont <= 1'b0;
      repeat (2) @(posedge clock_in);
      reset_in <= 1'b0;
      check(24'(exp_q.size()), 24'h000000);
      complete_run();
   end
endmodule : tb
`default_nettype wire
